// >>> verilog/spd_pkg.sv
/*
 * Shared constants and state types for the two-channel step/direction
 * motion generator: register offsets, channel selector codes, command
 * opcodes, timing counts and the packed state records.
 * Assumes a 25 MHz APB clock and a 12-bit APB byte address.
 */
package spd_pkg;

    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int              CLK_HZ        = 25_000_000;
    localparam int              CLK_PERIOD_NS = 40;
    localparam logic [24:0]     ACC_WRAP      = 25'(CLK_HZ);
    // Width of one step pulse, rounded up to whole cycles
    localparam int              STEP_PULSE_NS = 5000;
    localparam int              PULSE_CYC_I   = (STEP_PULSE_NS + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS;
    localparam logic [7:0]      PULSE_CYC     = 8'(PULSE_CYC_I);

    // ==========================================================
    // Rate limits and rate/ramp reset values (rates in pulses per second)
    // ==========================================================
    localparam logic [13:0]     RATE_MIN      = 14'h0001;
    localparam logic [13:0]     RATE_MAX      = 14'h2710;
    localparam logic [13:0]     RATE_RST      = 14'h0001;
    localparam logic [15:0]     RAMP_RST      = 16'h0000;

    // ==========================================================
    // Channel selector codes and command opcodes
    // ==========================================================
    localparam logic [7:0]      SEL_CTRL1     = 8'h01;
    localparam logic [7:0]      SEL_CH2       = 8'h02;
    localparam logic [7:0]      SEL_FULL1     = 8'h0b;
    localparam logic [7:0]      SEL_HALF1     = 8'h15;
    localparam logic [7:0]      SEL_CTRL2     = 8'h20;
    localparam logic [2:0]      OP_REL        = 3'h0;
    localparam logic [2:0]      OP_ABS        = 3'h1;
    localparam logic [2:0]      OP_STOP       = 3'h2;
    localparam logic [2:0]      OP_HOME       = 3'h3;
    localparam logic [2:0]      OP_SRST       = 3'h4;

    // ==========================================================
    // Register byte offsets
    // ==========================================================
    localparam logic [11:0]     OFS_SEL       = 12'h000;
    localparam logic [11:0]     OFS_ARG       = 12'h004;
    localparam logic [11:0]     OFS_CMD       = 12'h008;
    localparam logic [11:0]     OFS_RATE1     = 12'h00c;
    localparam logic [11:0]     OFS_RAMP1     = 12'h010;
    localparam logic [11:0]     OFS_RATE2     = 12'h014;
    localparam logic [11:0]     OFS_RAMP2     = 12'h018;
    localparam logic [11:0]     OFS_POS1      = 12'h01c;
    localparam logic [11:0]     OFS_POS2      = 12'h020;
    localparam logic [11:0]     OFS_STAT      = 12'h024;
    localparam logic [11:0]     OFS_MASK      = 12'h028;
    localparam logic [11:0]     OFS_RUN       = 12'h02c;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [2:0] {
        DRV_CTRL = 3'b001,
        DRV_FULL = 3'b010,
        DRV_HALF = 3'b100
    } spd_drv_e;

    typedef struct packed {
        logic           busy;
        spd_drv_e       drv;
        logic           dir;
        logic           down;
        logic [31:0]    total;
        logic [31:0]    issued;
        logic [31:0]    pos;
        logic [13:0]    rate;
        logic [13:0]    cur;
        logic [15:0]    ramp;
        logic [17:0]    frac;
        logic [24:0]    acc;
        logic [7:0]     pw;
        logic           step;
        logic [2:0]     phase;
    } spd_chan_s;

    typedef struct packed {
        spd_chan_s [1:0] ch;
        logic [7:0]     sel;
        logic [31:0]    arg;
        logic [1:0]     stat;
        logic [1:0]     mask;
        logic [31:0]    prdata;
        logic           pready;
        logic           pslverr;
        logic [3:0]     outs;
        logic           irq;
    } spd_state_s;

endpackage

// >>> verilog/spd_ctrl.sv
/*
 * Two-channel stepper motion generator with an APB register slave.
 * Channel 1 drives step/direction or four coils on outputs 5..8,
 * channel 2 drives step/direction on outputs 7..8. Trapezoidal ramp,
 * signed position tracking, sticky done flags with a masked interrupt.
 * Assumes an APB master on pclk; motor outputs go to pad drivers.
 */
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps

// Contract
// R01: Controller mode channel 1: direction on output 5, step pulses on output 6.
// R02: Direction high for negative motion, low for positive motion.
// R03: Selector 32 runs channel 2 as controller, direction output 7, step output 8.
// R04: Selector 11 drives channel 1 coils full-step on outputs 5 to 8.
// R05: Selector 21 drives channel 1 coils half-step; counts are half steps.
// R06: Channel 2 offers controller mode only, no coil driving.
// R07: Software loads rate and ramp before the first move after power-up.
// R08: Rate and ramp persist until rewritten; software reset keeps them.
// R09: Rate setting accepts 1 to 10000 pulses per second only.
// R10: Ramp value is steps to accelerate to full rate and to decelerate.
// R11: Ramp starts and ends at one eighth of the maximum rate.
// R12: Relative move emits magnitude-of-count pulses, sign picks direction.
// R13: Relative move start clears its done flag; flag set after last step.
// R14: Absolute move computes count and direction to signed target from home.
// R15: Absolute move start clears its done flag; flag set at target.
// R16: Set-home zeroes the position; position readable at any time.
// R17: New moves are ignored while a move runs until done or stopped.
// R18: Full-step cycles four coil states, half-step eight; reversed when negative.
// R19: Stop halts pulses at once, keeps issued position, channel ready again.
module spd_ctrl (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [11:0]    paddr,
    input  wire logic [31:0]    pwdata,
    output logic      [31:0]    prdata,
    output logic                pready,
    output logic                pslverr,
    output logic      [3:0]     motor_out,
    output logic                irq
);

    // ==========================================================
    // State
    // ==========================================================
    spd_pkg::spd_state_s q;
    spd_pkg::spd_state_s d;

    // Coil pattern per half-step phase; odd phases are the full-step states
    function automatic logic [3:0] coil_pattern(input logic [2:0] ph);
        logic [3:0] p;
        p = 4'h0;
        unique case (ph)
            3'h0: p = 4'h1;
            3'h1: p = 4'h3;
            3'h2: p = 4'h2;
            3'h3: p = 4'h6;
            3'h4: p = 4'h4;
            3'h5: p = 4'hc;
            3'h6: p = 4'h8;
            3'h7: p = 4'h9;
        endcase
        return p;
    endfunction

    // Clamp a written rate into the legal range
    function automatic logic [13:0] clamp_rate(input logic [31:0] v);
        logic [13:0] r;
        r = v[13:0];
        if (v > {18'h00000, spd_pkg::RATE_MAX}) begin
            r = spd_pkg::RATE_MAX;
        end else if (v == 32'h0000_0000) begin
            r = spd_pkg::RATE_MIN;
        end
        return r;
    endfunction

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb begin
        logic           setup;
        logic           wr;
        logic           mapped;
        logic [31:0]    rdv;
        logic [2:0]     op;
        logic           cidx;
        logic           sel_ok;
        spd_pkg::spd_drv_e nd;
        logic [32:0]    diff;
        logic [31:0]    mag;
        logic           ndir;
        logic [1:0]     done_set;
        logic [1:0]     done_clr;
        logic [13:0]    minr;
        logic [13:0]    delta;
        logic [31:0]    inew;
        logic [31:0]    rem;
        logic [31:0]    ramped;
        setup    = 1'b0;
        wr       = 1'b0;
        mapped   = 1'b0;
        rdv      = 32'h0000_0000;
        op       = 3'h0;
        cidx     = 1'b0;
        sel_ok   = 1'b0;
        nd       = spd_pkg::DRV_CTRL;
        diff     = 33'h0_0000_0000;
        mag      = 32'h0000_0000;
        ndir     = 1'b0;
        done_set = 2'b00;
        done_clr = 2'b00;
        minr     = 14'h0000;
        delta    = 14'h0000;
        inew     = 32'h0000_0000;
        rem      = 32'h0000_0000;
        ramped   = 32'h0000_0000;
        d        = q;

        // APB: answer in the first access cycle, data latched at setup
        setup    = psel && !penable;
        wr       = psel && penable && pwrite && q.pready;
        d.pready = setup;
        unique case (paddr)
            spd_pkg::OFS_SEL:   begin mapped = 1'b1; rdv = {24'h000000, q.sel}; end
            spd_pkg::OFS_ARG:   begin mapped = 1'b1; rdv = q.arg; end
            spd_pkg::OFS_CMD:   begin mapped = 1'b1; end
            spd_pkg::OFS_RATE1: begin mapped = 1'b1; rdv = {18'h00000, q.ch[0].rate}; end
            spd_pkg::OFS_RAMP1: begin mapped = 1'b1; rdv = {16'h0000, q.ch[0].ramp}; end
            spd_pkg::OFS_RATE2: begin mapped = 1'b1; rdv = {18'h00000, q.ch[1].rate}; end
            spd_pkg::OFS_RAMP2: begin mapped = 1'b1; rdv = {16'h0000, q.ch[1].ramp}; end
            spd_pkg::OFS_POS1:  begin mapped = 1'b1; rdv = q.ch[0].pos; end // see R16
            spd_pkg::OFS_POS2:  begin mapped = 1'b1; rdv = q.ch[1].pos; end // see R16
            spd_pkg::OFS_STAT:  begin mapped = 1'b1; rdv = {30'h0, q.stat}; end
            spd_pkg::OFS_MASK:  begin mapped = 1'b1; rdv = {30'h0, q.mask}; end
            spd_pkg::OFS_RUN:   begin
                mapped = 1'b1;
                rdv    = {25'h0, q.ch[0].drv, 2'b00, q.ch[1].busy, q.ch[0].busy};
            end
            default:            mapped = 1'b0;
        endcase
        if (setup) begin
            d.prdata  = pwrite ? 32'h0000_0000 : rdv;
            d.pslverr = !mapped;
        end else begin
            d.pslverr = 1'b0;
        end

        // Plain register writes; rates are clamped into range
        if (wr) begin
            unique case (paddr)
                spd_pkg::OFS_SEL:   d.sel = pwdata[7:0];
                spd_pkg::OFS_ARG:   d.arg = pwdata;
                spd_pkg::OFS_RATE1: d.ch[0].rate = clamp_rate(pwdata); // see R09
                spd_pkg::OFS_RAMP1: d.ch[0].ramp = pwdata[15:0];       // see R10
                spd_pkg::OFS_RATE2: d.ch[1].rate = clamp_rate(pwdata); // see R09
                spd_pkg::OFS_RAMP2: d.ch[1].ramp = pwdata[15:0];       // see R10
                spd_pkg::OFS_STAT:  done_clr = pwdata[1:0];
                spd_pkg::OFS_MASK:  d.mask = pwdata[1:0];
                default:            d.mask = d.mask;
            endcase
        end

        // Step engines, one pass per channel
        for (int i = 0; i < 2; i++) begin
            if (q.ch[i].pw != 8'h00) begin
                d.ch[i].pw = q.ch[i].pw - 8'h01;
            end else begin
                d.ch[i].step = 1'b0;
            end
            minr  = (q.ch[i].rate[13:3] == 11'h000) ? spd_pkg::RATE_MIN
                                                    : {3'b000, q.ch[i].rate[13:3]};
            delta = q.ch[i].rate - minr;
            if (q.ch[i].busy) begin
                // Phase accumulator gives a one-cycle step enable
                if ({11'h000, q.ch[i].cur} + q.ch[i].acc >= spd_pkg::ACC_WRAP) begin
                    d.ch[i].acc    = q.ch[i].acc + {11'h000, q.ch[i].cur}
                                     - spd_pkg::ACC_WRAP;
                    d.ch[i].step   = 1'b1;               // see R01 see R03
                    d.ch[i].pw     = spd_pkg::PULSE_CYC;
                    inew           = q.ch[i].issued + 32'h1;
                    d.ch[i].issued = inew;
                    d.ch[i].pos    = q.ch[i].dir ? q.ch[i].pos - 32'h1
                                                 : q.ch[i].pos + 32'h1;
                    // Coil sequence walks backwards for negative moves
                    if (q.ch[i].drv == spd_pkg::DRV_FULL) begin
                        d.ch[i].phase = q.ch[i].dir ? q.ch[i].phase - 3'h2
                                                    : q.ch[i].phase + 3'h2; // see R04 see R18
                    end else if (q.ch[i].drv == spd_pkg::DRV_HALF) begin
                        d.ch[i].phase = q.ch[i].dir ? q.ch[i].phase - 3'h1
                                                    : q.ch[i].phase + 3'h1; // see R05 see R18
                    end
                    // Ramp region: decelerate over as many steps as were ramped up
                    rem    = q.ch[i].total - inew;
                    ramped = (inew < {16'h0000, q.ch[i].ramp}) ? inew
                                                               : {16'h0000, q.ch[i].ramp};
                    if (rem <= ramped) begin
                        d.ch[i].frac = (q.ch[i].down ? q.ch[i].frac : 18'h0)
                                       + {4'h0, delta};                     // see R10
                        d.ch[i].down = 1'b1;
                    end else if (inew < {16'h0000, q.ch[i].ramp}) begin
                        d.ch[i].frac = q.ch[i].frac + {4'h0, delta};        // see R10
                    end else begin
                        d.ch[i].cur  = q.ch[i].rate;
                        d.ch[i].frac = 18'h0;
                    end
                    if (inew == q.ch[i].total) begin
                        d.ch[i].busy = 1'b0;
                        done_set[i]  = 1'b1;                    // see R13 see R15
                    end
                end else begin
                    d.ch[i].acc = q.ch[i].acc + {11'h000, q.ch[i].cur};
                    // Spread the rate change of each step over the following cycles
                    if (q.ch[i].ramp != 16'h0000 && q.ch[i].frac >= {2'b00, q.ch[i].ramp}) begin
                        d.ch[i].frac = q.ch[i].frac - {2'b00, q.ch[i].ramp};
                        if (q.ch[i].down) begin
                            d.ch[i].cur = (q.ch[i].cur > minr) ? q.ch[i].cur - 14'h1
                                                               : minr;       // see R11
                        end else begin
                            d.ch[i].cur = (q.ch[i].cur < q.ch[i].rate) ? q.ch[i].cur + 14'h1
                                                                       : q.ch[i].rate;
                        end
                    end
                end
            end
        end

        // Commands: the selector names channel and drive mode
        if (wr && paddr == spd_pkg::OFS_CMD) begin
            op   = pwdata[2:0];
            cidx = (q.sel == spd_pkg::SEL_CTRL2 || q.sel == spd_pkg::SEL_CH2);
            unique case (q.sel)
                spd_pkg::SEL_CTRL1: begin sel_ok = 1'b1; nd = spd_pkg::DRV_CTRL; end
                spd_pkg::SEL_FULL1: begin sel_ok = 1'b1; nd = spd_pkg::DRV_FULL; end
                spd_pkg::SEL_HALF1: begin sel_ok = 1'b1; nd = spd_pkg::DRV_HALF; end
                spd_pkg::SEL_CTRL2: begin sel_ok = 1'b1; nd = spd_pkg::DRV_CTRL; end // see R06
                default:            sel_ok = 1'b0;
            endcase
            // Pins 7..8 are shared: coil driving and channel 2 exclude each other
            if (cidx && q.ch[0].drv != spd_pkg::DRV_CTRL) begin
                sel_ok = 1'b0;                                               // see R06
            end
            if (!cidx && nd != spd_pkg::DRV_CTRL && q.ch[1].busy) begin
                sel_ok = 1'b0;
            end
            if ((op == spd_pkg::OP_REL || op == spd_pkg::OP_ABS) && sel_ok
                    && !q.ch[cidx].busy) begin                               // see R17
                if (op == spd_pkg::OP_REL) begin
                    ndir = q.arg[31];                                        // see R12
                    mag  = q.arg[31] ? 32'h0 - q.arg : q.arg;                // see R12
                end else begin
                    diff = {q.arg[31], q.arg} - {q.ch[cidx].pos[31], q.ch[cidx].pos}; // see R14
                    ndir = diff[32];
                    mag  = diff[32] ? 32'(33'h0 - diff) : diff[31:0];        // see R14
                end
                d.ch[cidx].drv    = nd;                        // see R04 see R05
                d.ch[cidx].dir    = ndir;                                    // see R02
                d.ch[cidx].total  = mag;
                d.ch[cidx].issued = 32'h0;
                d.ch[cidx].acc    = 25'h0;
                d.ch[cidx].frac   = 18'h0;
                d.ch[cidx].down   = 1'b0;
                d.ch[cidx].cur    = (q.ch[cidx].ramp == 16'h0000) ? q.ch[cidx].rate
                                     : ((q.ch[cidx].rate[13:3] == 11'h000)
                                        ? spd_pkg::RATE_MIN
                                        : {3'b000, q.ch[cidx].rate[13:3]}); // see R11
                if (nd == spd_pkg::DRV_FULL) begin
                    d.ch[cidx].phase = q.ch[cidx].phase | 3'h1;              // see R18
                end
                if (mag == 32'h0) begin
                    done_set[cidx] = 1'b1;                     // see R13 see R15
                end else begin
                    d.ch[cidx].busy = 1'b1;
                    done_clr[cidx]  = 1'b1;                    // see R13 see R15
                end
            end else if (op == spd_pkg::OP_STOP) begin
                d.ch[cidx].busy = 1'b0;                                      // see R19
                d.ch[cidx].step = 1'b0;                                      // see R19
                d.ch[cidx].pw   = 8'h00;
            end else if (op == spd_pkg::OP_HOME) begin
                d.ch[cidx].pos = 32'h0;                                      // see R16
            end else if (op == spd_pkg::OP_SRST) begin
                // Software reset aborts motion but keeps rate and ramp
                for (int k = 0; k < 2; k++) begin
                    d.ch[k].busy = 1'b0;                                     // see R08
                    d.ch[k].step = 1'b0;
                    d.ch[k].pw   = 8'h00;
                end
                done_clr = 2'b11;
            end
        end

        // Sticky done flags: a set in the same cycle beats any clear
        d.stat = (q.stat & ~done_clr) | done_set;
        d.irq  = |(q.stat & q.mask);

        // Output pins 5..8 (bit 0 is pin 5)
        if (q.ch[0].drv == spd_pkg::DRV_CTRL) begin
            d.outs = {q.ch[1].step, q.ch[1].dir, q.ch[0].step, q.ch[0].dir}; // see R01 see R03
        end else begin
            d.outs = coil_pattern(q.ch[0].phase);                  // see R04 see R05
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            for (int k = 0; k < 2; k++) begin
                q.ch[k].drv  <= spd_pkg::DRV_CTRL;
                q.ch[k].rate <= spd_pkg::RATE_RST;
                q.ch[k].ramp <= spd_pkg::RAMP_RST;
            end
        end else begin
            q <= d;
        end
    end

    // Outputs come straight from the state register
    assign prdata    = q.prdata;
    assign pready    = q.pready;
    assign pslverr   = q.pslverr;
    assign motor_out = q.outs;
    assign irq       = q.irq;

endmodule

// >>> tb/spd_drv_model.sv
/* External step/direction driver model: counts step pulses per channel.
   Assumes controller-mode wiring of motor_out; coil moves also bump cnt1. */
`timescale 1ns/10ps
module spd_drv_model (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic [3:0]         motor_out,
    output logic signed [31:0]      cnt1,
    output logic signed [31:0]      cnt2
);
    // ==========================================================
    // Count on the rising step edge; direction high means negative
    // ==========================================================
    logic [3:0] prev_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 4'h0;
            cnt1   <= 32'sh0;
            cnt2   <= 32'sh0;
        end else begin
            prev_q <= motor_out;
            if (motor_out[1] && !prev_q[1]) begin
                cnt1 <= motor_out[0] ? cnt1 - 1 : cnt1 + 1;
            end
            if (motor_out[3] && !prev_q[3]) begin
                cnt2 <= motor_out[2] ? cnt2 - 1 : cnt2 + 1;
            end
        end
    end
endmodule

// >>> tb/spd_ctrl_sva.sv
/* Port checker for spd_ctrl: APB answer timing and step pulse shape.
   Assumes the bind after the module; one clock domain. */
`timescale 1ns/10ps
module spd_ctrl_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [3:0]  motor_out,
    input wire logic        irq
);
    // ==========================================================
    // Properties
    // ==========================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Pulse is far wider than 8 cycles; 8 keeps the unroll cheap
    sequence s_step_hi; motor_out[1] [*8]; endsequence
    sequence s_step_lo; !motor_out[1] [*8]; endsequence
    a_zero_wait: assert property (psel && !penable |=> pready)
        else $error("pready missing in access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("pslverr without pready or with data");
    a_unmapped_err: assert property (psel && !penable && paddr > 12'h02c |=> pslverr)
        else $error("unmapped address not refused");
    a_mapped_ok: assert property (psel && !penable && paddr <= 12'h02c
        && paddr[1:0] == 2'b00 |=> !pslverr) else $error("mapped address refused");
    a_cmd_reads0: assert property (psel && !penable && !pwrite && paddr == 12'h008
        |=> prdata == 32'h0) else $error("command register read not zero");
    a_reset_idle: assert property ($rose(presetn) |-> motor_out == 4'h0 && !irq)
        else $error("outputs not idle after reset");
    a_step_width: assert property ($rose(motor_out[1]) |-> s_step_hi)
        else $error("step pulse too short");
    a_step_gap: assert property ($fell(motor_out[1]) |=> s_step_lo)
        else $error("step gap too short");
endmodule
bind spd_ctrl spd_ctrl_sva spd_ctrl_sva_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .motor_out, .irq);

// >>> tb/testbench.sv
/* Self-checking bench for spd_ctrl over APB with a step driver model.
   Assumes spd_pkg constants; waits are bounded polling loops, except the fixed 20-cycle reset wait and the 8000-cycle run before the stop. */
`timescale 1ns/10ps
module testbench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  motor_out;
    logic        irq;
    logic signed [31:0] cnt1;
    logic signed [31:0] cnt2;
    logic [31:0] rd;
    int          n_errors = 0;
    int          samples_checked = 0;
    // ==========================================================
    // Clock, design, driver model
    // ==========================================================
    always #20 pclk = ~pclk;
    spd_ctrl spd_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .motor_out, .irq);
    spd_drv_model spd_drv_model_inst (.pclk, .presetn, .motor_out, .cnt1, .cnt2);
    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Leading edge wait keeps back-to-back calls off one time step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin n_errors++; end_of_test(); end
        rd = prdata;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic move(input logic [7:0] s, input logic [31:0] a, input logic [2:0] op);
        apb(1, spd_pkg::OFS_SEL, {24'h0, s});
        apb(1, spd_pkg::OFS_ARG, a);
        apb(1, spd_pkg::OFS_CMD, {29'h0, op});
    endtask
    task automatic wait_stat(input int b);
        int k;
        k = 0;
        do begin apb(0, spd_pkg::OFS_STAT, 32'h0); k++; end while (rd[b] !== 1'b1 && k < 5000);
        if (k >= 5000) begin n_errors++; end_of_test(); end
        @(posedge pclk);
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_reset_rates();
        apb(0, spd_pkg::OFS_RATE1, 0); chk("rate1 rst", rd, 32'h1);
        apb(0, 12'h100, 0); chk("unmapped", rd, 32'h0);
        apb(1, spd_pkg::OFS_RATE1, 32'd20000); apb(0, spd_pkg::OFS_RATE1, 0);
        chk("rate clamp", rd, 32'h2710);
        apb(1, spd_pkg::OFS_CMD, {29'h0, spd_pkg::OP_SRST}); apb(0, spd_pkg::OFS_RATE1, 0);
        chk("rate kept", rd, 32'h2710);
        apb(1, spd_pkg::OFS_RAMP1, 0); apb(1, spd_pkg::OFS_RATE2, 32'h2710);
    endtask
    task automatic t_rel_neg();
        apb(1, spd_pkg::OFS_MASK, 32'h1);
        move(spd_pkg::SEL_CTRL1, -32'sd3, spd_pkg::OP_REL);
        move(spd_pkg::SEL_CTRL1, 32'd5, spd_pkg::OP_REL);
        wait_stat(0);
        chk("pulses ch1", cnt1, -32'sd3);
        apb(0, spd_pkg::OFS_POS1, 0); chk("pos1", rd, -32'sd3);
        chk("irq set", {31'h0, irq}, 32'h1);
        apb(1, spd_pkg::OFS_MASK, 0); apb(0, spd_pkg::OFS_RUN, 0);
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1, spd_pkg::OFS_MASK, 1); apb(1, spd_pkg::OFS_STAT, 1); apb(0, spd_pkg::OFS_STAT, 0);
        chk("stat w1c", rd, 32'h0); chk("irq clr", {31'h0, irq}, 32'h0);
    endtask
    task automatic t_abs_ch2();
        move(spd_pkg::SEL_CTRL2, 32'd2, spd_pkg::OP_ABS);
        wait_stat(1);
        chk("pulses ch2", cnt2, 32'd2);
        apb(0, spd_pkg::OFS_POS2, 0); chk("pos2", rd, 32'd2);
        move(spd_pkg::SEL_CH2, 0, spd_pkg::OP_HOME);
        apb(0, spd_pkg::OFS_POS2, 0); chk("home", rd, 32'h0);
    endtask
    task automatic t_stop_half();
        logic [31:0] p0;
        move(spd_pkg::SEL_CTRL1, 32'd1000, spd_pkg::OP_REL);
        repeat (8000) @(posedge pclk);
        move(spd_pkg::SEL_CTRL1, 0, spd_pkg::OP_STOP);
        apb(0, spd_pkg::OFS_POS1, 0); chk("pos stop", rd, cnt1);
        p0 = rd;
        apb(0, spd_pkg::OFS_RUN, 0); chk("idle stop", {31'h0, rd[0]}, 32'h0);
        move(spd_pkg::SEL_HALF1, 32'd2, spd_pkg::OP_REL);
        wait_stat(0);
        apb(0, spd_pkg::OFS_RUN, 0); chk("half mode", {29'h0, rd[6:4]}, 32'h4);
        apb(0, spd_pkg::OFS_POS1, 0); chk("half pos", rd, p0 + 32'd2);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_rates();
        t_rel_neg();
        t_abs_ch2();
        t_stop_half();
        end_of_test();
    end
endmodule
